// ### src/rtcsab_consts.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef RTCSAB_CONSTS_SVH
`define RTCSAB_CONSTS_SVH
`define RTCSAB_SLAVE_ADDR 8'hD0
`define RTCSAB_ADDR_SECS 5'h01
`define RTCSAB_ADDR_HOURS 5'h03
`define RTCSAB_ADDR_WDOG 5'h09
`define RTCSAB_ADDR_ALHR 5'h0C
`define RTCSAB_ADDR_FLAGS 5'h0F
`define RTCSAB_LAST_CLK 5'h07
`define RTCSAB_HALT_BIT 7
`define RTCSAB_FREEZE_BIT 6
`define RTCSAB_OSCF_BIT 2
`define RTCSAB_OSCIE_BIT 7
`define RTCSAB_MEM_RST 8'h00
`define RTCSAB_CNT_RST 64'h0001010100000000
`define RTCSAB_CLK_KHZ 25000
`define RTCSAB_REC_TIME_MS 210
`define RTCSAB_REC_CYCLES (`RTCSAB_REC_TIME_MS * `RTCSAB_CLK_KHZ)
`define RTCSAB_HUND_DIV 328
`endif

// ### src/rtcsab_pkg.sv
// Types shared by the serial access buffer block.
package rtcsab_pkg;
  typedef enum logic [2:0] {
    S_IDLE, S_RX, S_RX_ACK, S_TX, S_TX_ACK
  } rtcsab_state_t;

  typedef struct packed {
    logic en;
    logic [4:0] addr;
    logic [7:0] data;
  } rtcsab_wr_t;
endpackage

// ### src/rtcsab_top.sv
// Two-wire slave access path with buffer/transfer registers and counters.
//
// How it works
// - Each byte on the bus is followed by a ninth acknowledge bit.
// - Device pulls data low through the ack clock of each received byte.
// - Unacknowledged transmitted byte: device releases data line for STOP.
// - Pointer advances by one only on a data byte acknowledge clock.
// - Read continues at successive addresses while master acknowledges.
// - Matching slave address snapshots all counters into buffers at 00h-07h unless freeze bit is set.
// - Read without word address starts from the current pointer.
// - Write loads first byte into pointer, stores following bytes there.
// - Write acknowledges slave address, word address and each data byte.
// - Clock-range write loads buffers into counters at end or past 07h.
// - Unwritten clock bytes reload their snapshot values.
// - Bus ignored during power fail; counters and RAM keep running.
// - Reset output low on power fail and about 210 ms after return.
// - Recovery time affects only reset output; bus usable at once.
// - Seconds top bit halts the oscillator; clearing restarts it.
// - Century bits in hours top, day low three bits, BCD calendar.
// - Oscillator fail detector sets flag bit 2 of flags register.
// - Fail flag with its enable at watchdog bit 7 drives interrupt.
// - Any clock-range write reloads counters and resets the divider.
// - Device answers only its fixed slave address after START.
// - Power fail sets freeze bit 6 of 0Ch, blocking snapshots.
`timescale 1ns/1ns
`include "rtcsab_consts.svh"

module rtcsab_top #(
  parameter int REC_CYCLES = `RTCSAB_REC_CYCLES,
  parameter int HUND_DIV = `RTCSAB_HUND_DIV
) (
  // Clock, reset and enable.
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // Two-wire bus; data is open drain.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Supply monitor, timebase and oscillator detector.
  input wire logic power_fail_in,
  input wire logic osc_tick_in,
  input wire logic osc_fail_in,
  // Open-drain reset and oscillator-fail interrupt.
  output logic rst_oe_out,
  output logic osc_irq_out
);
  localparam int REC_W = $clog2(REC_CYCLES + 1);
  localparam int DIV_W = $clog2(HUND_DIV);
  localparam logic [63:0] CNT_RST = `RTCSAB_CNT_RST;
  localparam logic [7:0] SLAVE = `RTCSAB_SLAVE_ADDR;

  function automatic logic [8:0] bcd_step(input logic [7:0] v,
      input logic [7:0] maxv, input logic [7:0] minv);
    if (v >= maxv) begin
      return {1'b1, minv};
    end
    if (v[3:0] == 4'h9) begin
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    end
    return {1'b0, v[7:4], v[3:0] + 4'h1};
  endfunction

  // Leap years are those divisible by four within the century.
  function automatic logic [7:0] month_len(input logic [7:0] mon,
      input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    unique case (mon)
      8'h02: return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction

  rtcsab_pkg::rtcsab_state_t state_reg, state_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next;
  logic [1:0] idx_reg, idx_next;
  logic [4:0] ptr_reg, ptr_next;
  logic rw_reg, rw_next, dirty_reg, dirty_next, oe_reg, oe_next;
  logic mack_reg, mack_next, scl_reg, sda_reg;
  logic [7:0] mem_reg [0:31];
  logic [7:0] mem_next [0:31];
  logic [7:0] cnt_reg [0:7];
  logic [7:0] cnt_next [0:7];
  logic [DIV_W-1:0] div_reg, div_next;
  logic [REC_W-1:0] rec_reg, rec_next;
  logic pf_reg, rst_reg, rst_next, irq_reg, irq_next, sdo_reg;
  rtcsab_pkg::rtcsab_wr_t wr;
  logic load, snap, rise, fall, start_det, stop_det, freeze;
  logic [7:0] rd_byte;

  assign rise = scl_in & ~scl_reg;
  assign fall = ~scl_in & scl_reg;
  assign start_det = scl_in & scl_reg & sda_reg & ~sda_in;
  assign stop_det = scl_in & scl_reg & ~sda_reg & sda_in;
  assign freeze = mem_reg[`RTCSAB_ADDR_ALHR][`RTCSAB_FREEZE_BIT];
  assign rd_byte = mem_reg[ptr_reg];
  assign sda_out = sdo_reg;
  assign sda_oe_out = oe_reg;
  assign rst_oe_out = rst_reg;
  assign osc_irq_out = irq_reg;

  // Bus protocol engine.
  always_comb begin
    state_next = state_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    idx_next = idx_reg;
    rw_next = rw_reg;
    ptr_next = ptr_reg;
    dirty_next = dirty_reg;
    oe_next = oe_reg;
    mack_next = mack_reg;
    wr = '0;
    load = 1'b0;
    snap = 1'b0;
    if (power_fail_in) begin
      state_next = rtcsab_pkg::S_IDLE;
      oe_next = 1'b0;
      ptr_next = 5'h00;
      dirty_next = 1'b0;
    end else if (start_det || stop_det) begin
      // A repeated start also ends a write, so it triggers the load-back.
      load = dirty_reg;
      dirty_next = 1'b0;
      oe_next = 1'b0;
      state_next = start_det ? rtcsab_pkg::S_RX : rtcsab_pkg::S_IDLE;
      bit_next = 4'h0;
      idx_next = 2'd0;
    end else begin
      unique case (state_reg)
        rtcsab_pkg::S_IDLE: begin
        end
        rtcsab_pkg::S_RX: begin
          if (rise) begin
            sh_next = {sh_reg[6:0], sda_in};
            bit_next = bit_reg + 4'h1;
          end
          if (fall && bit_reg == 4'h8) begin
            bit_next = 4'h0;
            oe_next = 1'b1;
            state_next = rtcsab_pkg::S_RX_ACK;
            if (idx_reg == 2'd0) begin
              if (sh_reg[7:1] != SLAVE[7:1]) begin
                oe_next = 1'b0;
                state_next = rtcsab_pkg::S_IDLE;
              end else begin
                rw_next = sh_reg[0];
                snap = ~freeze;
              end
            end else if (idx_reg == 2'd1) begin
              ptr_next = sh_reg[4:0];
            end else begin
              wr = '{en: 1'b1, addr: ptr_reg, data: sh_reg};
              if (ptr_reg <= `RTCSAB_LAST_CLK) begin
                dirty_next = 1'b1;
              end
            end
          end
        end
        rtcsab_pkg::S_RX_ACK: begin
          if (fall) begin
            oe_next = 1'b0;
            state_next = rtcsab_pkg::S_RX;
            if (idx_reg == 2'd2) begin
              ptr_next = ptr_reg + 5'h01;
              if (ptr_reg == `RTCSAB_LAST_CLK && dirty_reg) begin
                load = 1'b1;
                dirty_next = 1'b0;
              end
            end
            if (idx_reg == 2'd0 && rw_reg) begin
              state_next = rtcsab_pkg::S_TX;
              sh_next = rd_byte;
              oe_next = ~rd_byte[7];
              bit_next = 4'h1;
            end else if (idx_reg != 2'd2) begin
              idx_next = idx_reg + 2'd1;
            end
          end
        end
        rtcsab_pkg::S_TX: begin
          if (fall) begin
            if (bit_reg == 4'h8) begin
              oe_next = 1'b0;
              state_next = rtcsab_pkg::S_TX_ACK;
            end else begin
              sh_next = {sh_reg[6:0], 1'b0};
              oe_next = ~sh_reg[6];
              bit_next = bit_reg + 4'h1;
            end
          end
        end
        rtcsab_pkg::S_TX_ACK: begin
          if (rise) begin
            mack_next = ~sda_in;
            if (!sda_in) begin
              ptr_next = ptr_reg + 5'h01;
            end
          end
          if (fall) begin
            if (mack_reg) begin
              state_next = rtcsab_pkg::S_TX;
              sh_next = rd_byte;
              oe_next = ~rd_byte[7];
              bit_next = 4'h1;
            end else begin
              state_next = rtcsab_pkg::S_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= rtcsab_pkg::S_IDLE;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      idx_reg <= 2'd0;
      ptr_reg <= 5'h00;
      rw_reg <= 1'b0;
      dirty_reg <= 1'b0;
      oe_reg <= 1'b0;
      mack_reg <= 1'b0;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      sdo_reg <= 1'b0;
    end else if (ce_in) begin
      state_reg <= state_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      idx_reg <= idx_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      dirty_reg <= dirty_next;
      oe_reg <= oe_next;
      mack_reg <= mack_next;
      scl_reg <= scl_in;
      sda_reg <= sda_in;
    end
  end

  // Counters, buffer/transfer registers and the rest of the byte map.
  always_comb begin
    logic [8:0] r;
    logic c;
    r = 9'h000;
    c = 1'b0;
    for (int i = 0; i < 32; i++) begin
      mem_next[i] = mem_reg[i];
    end
    for (int i = 0; i < 8; i++) begin
      cnt_next[i] = cnt_reg[i];
    end
    div_next = div_reg;
    if (load) begin
      for (int i = 0; i < 8; i++) begin
        cnt_next[i] = mem_reg[i];
      end
      div_next = '0;
    end else if (osc_tick_in
                 && !cnt_reg[1][`RTCSAB_HALT_BIT]) begin
      if (div_reg == DIV_W'(HUND_DIV - 1)) begin
        div_next = '0;
        r = bcd_step(cnt_reg[0], 8'h99, 8'h00);
        cnt_next[0] = r[7:0];
        c = r[8];
        if (c) begin
          r = bcd_step({1'b0, cnt_reg[1][6:0]}, 8'h59, 8'h00);
          cnt_next[1] = {cnt_reg[1][7], r[6:0]};
          c = r[8];
        end
        if (c) begin
          r = bcd_step(cnt_reg[2], 8'h59, 8'h00);
          cnt_next[2] = r[7:0];
          c = r[8];
        end
        if (c) begin
          r = bcd_step({2'b00, cnt_reg[3][5:0]}, 8'h23, 8'h00);
          cnt_next[3] = {cnt_reg[3][7:6], r[5:0]};
          c = r[8];
        end
        if (c) begin
          r = bcd_step({5'h00, cnt_reg[4][2:0]}, 8'h07, 8'h01);
          cnt_next[4] = r[7:0];
          r = bcd_step(cnt_reg[5], month_len(cnt_reg[6], cnt_reg[7]),
                       8'h01);
          cnt_next[5] = r[7:0];
          c = r[8];
        end
        if (c) begin
          r = bcd_step(cnt_reg[6], 8'h12, 8'h01);
          cnt_next[6] = r[7:0];
          c = r[8];
        end
        if (c) begin
          r = bcd_step(cnt_reg[7], 8'h99, 8'h00);
          cnt_next[7] = r[7:0];
          cnt_next[3][7:6] = cnt_next[3][7:6] + 2'h1;
        end
      end else begin
        div_next = div_reg + DIV_W'(1);
      end
    end
    if (snap) begin
      for (int i = 0; i < 8; i++) begin
        mem_next[i] = cnt_reg[i];
      end
    end
    if (wr.en) begin
      mem_next[wr.addr] = wr.data;
    end
    // Hardware sets below are placed after the bus write so they win.
    if (power_fail_in && !pf_reg) begin
      mem_next[`RTCSAB_ADDR_ALHR][`RTCSAB_FREEZE_BIT] = 1'b1;
    end
    if (osc_fail_in) begin
      mem_next[`RTCSAB_ADDR_FLAGS][`RTCSAB_OSCF_BIT] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < 32; i++) begin
        mem_reg[i] <= `RTCSAB_MEM_RST;
      end
      for (int i = 0; i < 8; i++) begin
        cnt_reg[i] <= CNT_RST[8*i +: 8];
      end
      div_reg <= '0;
    end else if (ce_in) begin
      for (int i = 0; i < 32; i++) begin
        mem_reg[i] <= mem_next[i];
      end
      for (int i = 0; i < 8; i++) begin
        cnt_reg[i] <= cnt_next[i];
      end
      div_reg <= div_next;
    end
  end

  // Reset output and interrupt; recovery never gates the bus.
  always_comb begin
    rec_next = power_fail_in ? REC_W'(REC_CYCLES)
             : (rec_reg != '0) ? rec_reg - REC_W'(1) : rec_reg;
    rst_next = power_fail_in || (rec_next != '0);
    irq_next = mem_reg[`RTCSAB_ADDR_FLAGS][`RTCSAB_OSCF_BIT]
             & mem_reg[`RTCSAB_ADDR_WDOG][`RTCSAB_OSCIE_BIT];
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rec_reg <= REC_W'(REC_CYCLES);
      rst_reg <= 1'b1;
      irq_reg <= 1'b0;
      pf_reg <= 1'b0;
    end else if (ce_in) begin
      rec_reg <= rec_next;
      rst_reg <= rst_next;
      irq_reg <= irq_next;
      pf_reg <= power_fail_in;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  property p_ack_drive;
    state_reg == rtcsab_pkg::S_RX_ACK |-> oe_reg;
  endproperty
  a_ack_drive: assert property (p_ack_drive)
    else $error("receive ack not driven low");

  property p_tx_release;
    state_reg == rtcsab_pkg::S_TX_ACK |-> !oe_reg;
  endproperty
  a_tx_release: assert property (p_tx_release)
    else $error("data line held during master ack");

  property p_ptr_step;
    ce_in && !power_fail_in && (ptr_next != ptr_reg) && idx_reg != 2'd1
      |-> ptr_next == ptr_reg + 5'h01 && (rise || fall);
  endproperty
  a_ptr_step: assert property (p_ptr_step)
    else $error("pointer moved other than by one on ack clock");

  property p_rst_hold;
    ce_in && power_fail_in |=> rst_oe_out [*2];
  endproperty
  a_rst_hold: assert property (p_rst_hold)
    else $error("reset output not held on power fail");

  property p_bus_live;
    ce_in && start_det && !power_fail_in |=> state_reg == rtcsab_pkg::S_RX;
  endproperty
  a_bus_live: assert property (p_bus_live)
    else $error("start not accepted with supply good");

  property p_load_back;
    ce_in && load |=> cnt_reg[2] == $past(mem_reg[2]) && div_reg == '0;
  endproperty
  a_load_back: assert property (p_load_back)
    else $error("counters not loaded from buffers");

  property p_snapshot;
    ce_in && snap |=> mem_reg[0] == $past(cnt_reg[0])
                   && mem_reg[7] == $past(cnt_reg[7]);
  endproperty
  a_snapshot: assert property (p_snapshot)
    else $error("buffers not loaded from counters");

  property p_osc_flag;
    ce_in && osc_fail_in |=> mem_reg[`RTCSAB_ADDR_FLAGS][`RTCSAB_OSCF_BIT];
  endproperty
  a_osc_flag: assert property (p_osc_flag)
    else $error("oscillator fail flag not set");

  property p_irq;
    ce_in && irq_next |=> osc_irq_out;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt missing for enabled fail flag");

  property p_freeze;
    ce_in && $rose(power_fail_in) |=> freeze && !snap;
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("freeze bit not set on power fail");
endmodule

// ### verif/rtcsab_master.sv
// Behavioural two-wire bus master that drives the block's bus pins.
`timescale 1ns/1ns
module rtcsab_master (
  // Clock and device drive.
  input wire logic clk_in,
  input wire logic dev_oe_in,
  // Resolved bus lines.
  output logic scl_out,
  output logic sda_out
);
  logic drv_low;
  // The line has a pull-up, so a wire nobody pulls reads high.
  assign sda_out = ~(drv_low | dev_oe_in);
  initial begin
    scl_out = 1'b1;
    drv_low = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge clk_in);
  endtask
  // Data moves only in the middle of the low phase, never near an edge.
  task automatic bit_io(input logic b, output logic s);
    half();
    drv_low = ~b;
    half();
    scl_out = 1'b1;
    half();
    s = sda_out;
    scl_out = 1'b0;
  endtask
  task automatic start();
    half();
    drv_low = 1'b0;
    half();
    scl_out = 1'b1;
    half();
    drv_low = 1'b1;
    half();
    scl_out = 1'b0;
  endtask
  task automatic stop();
    half();
    drv_low = 1'b1;
    half();
    scl_out = 1'b1;
    half();
    drv_low = 1'b0;
    half();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~ack, s);
  endtask
endmodule

// ### verif/rtcsab_top_bench.sv
// Self-checking bench for the two-wire access path and its counters.
`timescale 1ns/1ns
`include "rtcsab_consts.svh"
module rtcsab_top_bench;
  localparam int REC = 20;
  logic core_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic ce_in = 1'b1;
  logic power_fail_in = 1'b0;
  logic osc_tick_in = 1'b0;
  logic osc_fail_in = 1'b0;
  logic scl, sda, sda_out, sda_oe_out, rst_oe_out, osc_irq_out, ack;
  int err_count = 0;
  int num_checks = 0;
  logic [7:0] rb [8];
  always #20 core_clk_in = ~core_clk_in;
  rtcsab_top #(.REC_CYCLES(REC), .HUND_DIV(2)) rtcsab_top_inst (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .ce_in(ce_in),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .power_fail_in(power_fail_in),
    .osc_tick_in(osc_tick_in), .osc_fail_in(osc_fail_in),
    .rst_oe_out(rst_oe_out), .osc_irq_out(osc_irq_out));
  rtcsab_master rtcsab_master_inst (
    .clk_in(core_clk_in), .dev_oe_in(sda_oe_out),
    .scl_out(scl), .sda_out(sda));
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("Checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic addr_wr(input logic [7:0] a);
    rtcsab_master_inst.start();
    rtcsab_master_inst.wbyte(`RTCSAB_SLAVE_ADDR, ack);
    chk("slave ack", ack, 1'b1);
    rtcsab_master_inst.wbyte(a, ack);
    chk("word ack", ack, 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_wr(a);
    rtcsab_master_inst.wbyte(d, ack);
    chk("data ack", ack, 1'b1);
    rtcsab_master_inst.stop();
  endtask
  // With cur set the word address is skipped and the pointer is used.
  task automatic rd(input logic [7:0] a, input int n, input logic cur);
    if (!cur) begin
      addr_wr(a);
    end
    rtcsab_master_inst.start();
    rtcsab_master_inst.wbyte(`RTCSAB_SLAVE_ADDR | 8'h01, ack);
    chk("read ack", ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      rtcsab_master_inst.rbyte(i < n - 1, rb[i]);
    end
    repeat (2) @(negedge core_clk_in);
    chk("released", sda_oe_out, 1'b0);
    rtcsab_master_inst.stop();
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      osc_tick_in = 1'b1;
      @(negedge core_clk_in);
      osc_tick_in = 1'b0;
      repeat (2) @(negedge core_clk_in);
    end
  endtask
  task automatic t_reset();
    chk("irq idle", osc_irq_out, 1'b0);
    repeat (REC - 2) @(negedge core_clk_in);
    chk("rst held", rst_oe_out, 1'b1);
    repeat (4) @(negedge core_clk_in);
    chk("rst free", rst_oe_out, 1'b0);
  endtask
  // Two bytes in one write, then reads that end on a refused byte.
  task automatic t_rw();
    addr_wr(8'h01);
    rtcsab_master_inst.wbyte(8'h45, ack);
    chk("data ack", ack, 1'b1);
    rtcsab_master_inst.wbyte(8'h30, ack);
    chk("data ack", ack, 1'b1);
    rtcsab_master_inst.stop();
    rd(8'h01, 2, 1'b0);
    chk("sec", rb[0], 8'h45);
    chk("min", rb[1], 8'h30);
    rd(8'h00, 1, 1'b1);
    chk("cur", rb[0], 8'h30);
  endtask
  task automatic t_keep();
    logic [7:0] e [8] = '{8'h00, 8'h45, 8'h30, 8'hC5,
                          8'h01, 8'h01, 8'h01, 8'h00};
    wr(8'h03, 8'hC5);
    rd(8'h00, 8, 1'b0);
    for (int i = 0; i < 8; i++) begin
      chk("clock byte", rb[i], e[i]);
    end
  endtask
  task automatic t_addr();
    rtcsab_master_inst.start();
    rtcsab_master_inst.wbyte(8'hA0, ack);
    chk("foreign ack", ack, 1'b0);
    rtcsab_master_inst.stop();
  endtask
  task automatic t_pf();
    power_fail_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    chk("rst pf", rst_oe_out, 1'b1);
    rtcsab_master_inst.start();
    rtcsab_master_inst.wbyte(`RTCSAB_SLAVE_ADDR, ack);
    chk("pf ack", ack, 1'b0);
    rtcsab_master_inst.stop();
    power_fail_in = 1'b0;
    repeat (4) @(negedge core_clk_in);
    chk("rst rec", rst_oe_out, 1'b1);
    rd(8'h0C, 1, 1'b0);
    chk("freeze", rb[0], 8'h40);
    wr(8'h0C, 8'h00);
  endtask
  task automatic t_osc();
    osc_fail_in = 1'b1;
    @(negedge core_clk_in);
    osc_fail_in = 1'b0;
    rd(8'h0F, 1, 1'b0);
    chk("fail flag", rb[0], 8'h04);
    chk("irq off", osc_irq_out, 1'b0);
    wr(8'h09, 8'h80);
    chk("irq on", osc_irq_out, 1'b1);
    wr(8'h0F, 8'h00);
    chk("irq clr", osc_irq_out, 1'b0);
  endtask
  // Each write below restarts the divider, so tick counts are exact.
  task automatic t_count();
    wr(8'h00, 8'h00);
    ticks(24);
    rd(8'h00, 1, 1'b0);
    chk("hund", rb[0], 8'h12);
    wr(8'h01, 8'h80);
    ticks(24);
    rd(8'h00, 2, 1'b0);
    chk("halted", rb[0], 8'h12);
    chk("halt bit", rb[1], 8'h80);
    wr(8'h01, 8'h00);
    ticks(4);
    rd(8'h00, 1, 1'b0);
    chk("restart", rb[0], 8'h14);
  endtask
  // Enable low must freeze the reset timer and the counters.
  task automatic t_ce();
    ce_in = 1'b0;
    power_fail_in = 1'b1;
    ticks(4);
    chk("ce rst", rst_oe_out, 1'b0);
    power_fail_in = 1'b0;
    ce_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    chk("ce rst after", rst_oe_out, 1'b0);
    rd(8'h00, 2, 1'b0);
    chk("ce hund", rb[0], 8'h14);
    chk("ce halt", rb[1], 8'h00);
  endtask
  // About ten thousand cycles are expected; this allows several times more.
  initial begin
    #2000000;
    err_count++;
    results();
  end
  initial begin
    repeat (4) @(negedge core_clk_in);
    nrst_in = 1'b1;
    t_reset();
    t_rw();
    t_keep();
    t_addr();
    t_pf();
    t_osc();
    t_count();
    t_ce();
    chk("drive level", sda_out, 1'b0);
    results();
  end
endmodule
